// ### pid_loop_mode_transfer_ctrl.v
/*
 * mode, transfer and data format control of one pid loop: sample
 * scheduling, manual/auto/cascade modes, bumpless transfer, setpoint
 * and output limiting. tuning gains, error shaping and alarms are not
 * here; the control equation is unity-gain.
 * assumes measuredPv, cascadeSp, minorPv and ladderDone come from logic
 * on clk_sys; runMode comes from a pin and is synchronised here.
 */
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ns
`include "pid_loop_map.vh"
module pid_loop_mode_transfer_ctrl
#(
   parameter TICK_CYCLES = `PERIOD_UNIT_NS / `CLK_PERIOD_NS
)
(
   input  wire        clk_sys,
   input  wire        rst_n,
   input  wire [7:0]  regAddr,
   input  wire [15:0] regWrData,
   input  wire        regWr,
   input  wire        regRd,
   output reg  [15:0] regRdData,
   input  wire        runMode,
   input  wire        ladderDone,
   input  wire [15:0] measuredPv,
   input  wire [15:0] cascadeSp,
   input  wire [15:0] minorPv,
   output reg  [15:0] controlOut,
   output reg         calcDone
);

   // ****************************************
   // registers and state
   // ****************************************
   reg  [15:0] modeOne_reg;
   reg  [15:0] setpoint_reg;
   reg  [15:0] spUpper_reg;
   reg  [15:0] spLower_reg;
   reg  [15:0] outUpper_reg;
   reg  [15:0] outLower_reg;
   reg  [15:0] period_reg;
   reg  signed [17:0] bias_reg;
   reg  signed [17:0] prevErr_reg;
   reg  [1:0]  loopMode_reg;
   reg         refused_reg;
   reg         runMeta_reg;
   reg         run_reg;
   reg  [31:0] tickCnt_reg;
   reg  [15:0] periodCnt_reg;
   reg         due_reg;

   reg  [15:0] setpoint_next;
   reg  [15:0] ctrlOut_next;
   reg  signed [17:0] bias_next;
   reg  [1:0]  loopMode_next;
   reg         refused_next;

   wire        velocity;
   wire        reverse;
   wire        transferTwo;
   wire [1:0]  widthSel;
   wire        bipolar;
   wire        spLimitEn;
   wire [1:0]  effMode;
   wire [15:0] periodEff;
   wire        tick;
   wire        calcGo;
   wire        modeWr;
   wire [1:0]  reqMode;
   wire        reqValid;

   // ****************************************
   // configuration decode
   // ****************************************
   assign velocity    = modeOne_reg[`BIT_ALGO_VELOCITY];
   assign reverse     = modeOne_reg[`BIT_REVERSE];
   assign transferTwo = modeOne_reg[`BIT_TRANSFER_TWO];
   assign widthSel    = modeOne_reg[`BIT_WIDTH_HI:`BIT_WIDTH_LO];
   // a 16-bit word has no room for a sign bit
   assign bipolar     = modeOne_reg[`BIT_BIPOLAR] & (widthSel != `WIDTH_16);
   assign spLimitEn   = modeOne_reg[`BIT_SP_LIMIT_EN];

   // loop mode as seen by the equation, scheduling and status read; mode requests use the stored mode, which survives program
   assign effMode = run_reg ? loopMode_reg : `MODE_MANUAL;

   // ****************************************
   // common format conversions
   // ****************************************
   wire signed [17:0] spWordVal;
   wire signed [17:0] cascadeVal;
   wire signed [17:0] pvVal;
   wire signed [17:0] spUpperVal;
   wire signed [17:0] spLowerVal;
   wire signed [17:0] outUpperVal;
   wire signed [17:0] outLowerVal;
   wire signed [17:0] outVal;

   // one format drives every conversion
   pid_fmt_decode decSp     (.dataWord(setpoint_reg), .bipolar(bipolar), .value(spWordVal));
   pid_fmt_decode decCasc   (.dataWord(cascadeSp),    .bipolar(bipolar), .value(cascadeVal));
   pid_fmt_decode decPv     (.dataWord(measuredPv),   .bipolar(bipolar), .value(pvVal));
   pid_fmt_decode decSpUp   (.dataWord(spUpper_reg),  .bipolar(bipolar), .value(spUpperVal));
   pid_fmt_decode decSpLo   (.dataWord(spLower_reg),  .bipolar(bipolar), .value(spLowerVal));
   pid_fmt_decode decOutUp  (.dataWord(outUpper_reg), .bipolar(bipolar), .value(outUpperVal));
   pid_fmt_decode decOutLo  (.dataWord(outLower_reg), .bipolar(bipolar), .value(outLowerVal));
   pid_fmt_decode decOut    (.dataWord(controlOut),   .bipolar(bipolar), .value(outVal));

   // ****************************************
   // control equation
   // ****************************************
   reg  signed [17:0] spRaw;
   reg  signed [17:0] spUsed;
   reg  signed [17:0] errVal;
   reg  signed [17:0] rawOut;
   reg  signed [17:0] limOut;
   wire [15:0]        outWord;

   always @*
   begin
      spRaw = (effMode == `MODE_CASCADE) ? cascadeVal : spWordVal;
      spUsed = spRaw;
      if (spLimitEn)
      begin
         if (spRaw > spUpperVal)
            spUsed = spUpperVal;
         else if (spRaw < spLowerVal)
            spUsed = spLowerVal;
      end
      errVal = spUsed - pvVal;
      if (reverse)
         errVal = 18'h00000 - errVal;
      // velocity form adds the error change to the last output
      if (velocity)
         rawOut = outVal + (errVal - prevErr_reg);
      else
         rawOut = bias_reg + errVal;
      limOut = rawOut;
      if (rawOut > outUpperVal)
         limOut = outUpperVal;
      else if (rawOut < outLowerVal)
         limOut = outLowerVal;
   end

   // final clamp to the data range also enforces the documented spans
   pid_fmt_encode encOut
   (
      .value   (limOut),
      .widthSel(widthSel),
      .bipolar (bipolar),
      .dataWord(outWord)
   );

   // ****************************************
   // sample scheduling
   // ****************************************
   assign periodEff = (period_reg < `PERIOD_MIN) ? `PERIOD_MIN :
                      (period_reg > `PERIOD_MAX) ? `PERIOD_MAX : period_reg;
   assign tick      = (tickCnt_reg == (TICK_CYCLES - 1));
   // only at the end of the ladder task, and never in manual
   assign calcGo    = due_reg & ladderDone & run_reg & (effMode != `MODE_MANUAL);

   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         runMeta_reg   <= 1'b0;
         run_reg       <= 1'b0;
         tickCnt_reg   <= 32'h00000000;
         periodCnt_reg <= 16'h0000;
         due_reg       <= 1'b0;
      end
      else
      begin
         runMeta_reg <= runMode;
         run_reg     <= runMeta_reg;
         if (tick)
            tickCnt_reg <= 32'h00000000;
         else
            tickCnt_reg <= tickCnt_reg + 32'h00000001;
         if (calcGo)
         begin
            periodCnt_reg <= 16'h0000;
            due_reg       <= 1'b0;
         end
         else if (tick)
         begin
            if (periodCnt_reg + 16'h0001 >= periodEff)
               due_reg <= 1'b1;
            else
               periodCnt_reg <= periodCnt_reg + 16'h0001;
         end
      end
   end

   // ****************************************
   // mode requests and bumpless transfer
   // ****************************************
   assign modeWr   = regWr & (regAddr == `IDX_MODE_REQ);
   assign reqMode  = regWrData[1:0];
   assign reqValid = (reqMode == `MODE_MANUAL) | (reqMode == `MODE_AUTO) |
                     (reqMode == `MODE_CASCADE);

   always @*
   begin
      setpoint_next = setpoint_reg;
      ctrlOut_next  = controlOut;
      bias_next     = bias_reg;
      loopMode_next = loopMode_reg;
      refused_next  = refused_reg;
      if (regWr & (regAddr == `IDX_SETPOINT))
         setpoint_next = regWrData;
      if (regWr & (regAddr == `IDX_CTRL_OUT))
         ctrlOut_next = regWrData;
      if (calcGo)
      begin
         ctrlOut_next = outWord;
         if (!velocity)
            bias_next = bias_reg;
      end
      // mode changes are held off while the controller is in program mode
      if (modeWr & reqValid & run_reg)
      begin
         if ((loopMode_reg == `MODE_MANUAL) & (reqMode == `MODE_CASCADE))
            refused_next = 1'b1;
         else
         begin
            loopMode_next = reqMode;
            refused_next  = 1'b0;
            if ((loopMode_reg == `MODE_MANUAL) & (reqMode == `MODE_AUTO))
            begin
               if (!transferTwo)
                  setpoint_next = measuredPv;
               if (!velocity)
                  bias_next = outVal;
            end
            if ((loopMode_reg == `MODE_AUTO) & (reqMode == `MODE_CASCADE) & !transferTwo)
               ctrlOut_next = minorPv;
         end
      end
   end

   // ****************************************
   // register file
   // ****************************************
   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         modeOne_reg  <= `RST_WORD;
         setpoint_reg <= `RST_WORD;
         spUpper_reg  <= `RST_WORD;
         spLower_reg  <= `RST_WORD;
         outUpper_reg <= `RST_OUT_UPPER;
         outLower_reg <= `RST_WORD;
         period_reg   <= `RST_PERIOD;
         controlOut   <= `RST_WORD;
         bias_reg     <= 18'h00000;
         prevErr_reg  <= 18'h00000;
         loopMode_reg <= `MODE_MANUAL;
         refused_reg  <= 1'b0;
         calcDone     <= 1'b0;
      end
      else
      begin
         setpoint_reg <= setpoint_next;
         controlOut   <= ctrlOut_next;
         bias_reg     <= bias_next;
         loopMode_reg <= loopMode_next;
         refused_reg  <= refused_next;
         calcDone     <= calcGo;
         if (calcGo)
            prevErr_reg <= errVal;
         if (regWr)
         begin
            case (regAddr)
               `IDX_MODE_ONE:      modeOne_reg  <= regWrData;
               `IDX_SP_UPPER:      spUpper_reg  <= regWrData;
               `IDX_SP_LOWER:      spLower_reg  <= regWrData;
               `IDX_OUT_UPPER:     outUpper_reg <= regWrData;
               `IDX_OUT_LOWER:     outLower_reg <= regWrData;
               `IDX_SAMPLE_PERIOD: period_reg   <= regWrData;
               default:            period_reg   <= period_reg;
            endcase
         end
      end
   end

   // ****************************************
   // read port
   // ****************************************
   reg [15:0] rdMux;
   reg [15:0] biasWord;

   always @*
   begin
      biasWord = bias_reg[15:0];
      case (regAddr)
         `IDX_MODE_ONE:      rdMux = modeOne_reg;
         `IDX_SETPOINT:      rdMux = setpoint_reg;
         `IDX_CTRL_OUT:      rdMux = controlOut;
         `IDX_MODE_STATUS:   rdMux = {13'h0000, effMode == `MODE_CASCADE,
                                      effMode == `MODE_AUTO,
                                      effMode == `MODE_MANUAL};
         `IDX_MODE_REQ:      rdMux = {refused_reg, 13'h0000, loopMode_reg};
         `IDX_SP_UPPER:      rdMux = spUpper_reg;
         `IDX_SP_LOWER:      rdMux = spLower_reg;
         `IDX_OUT_UPPER:     rdMux = outUpper_reg;
         `IDX_OUT_LOWER:     rdMux = outLower_reg;
         `IDX_SAMPLE_PERIOD: rdMux = period_reg;
         `IDX_BIAS:          rdMux = biasWord;
         default:            rdMux = 16'h0000;
      endcase
   end

   // data stands only in the cycle after the strobe
   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         regRdData <= 16'h0000;
      else if (regRd)
         regRdData <= rdMux;
      else
         regRdData <= 16'h0000;
   end

endmodule

// ### pid_loop_map.vh
/*
 * register indices, field positions, reset values and timing figures
 * for the pid loop mode and transfer controller.
 * assumes a word-addressed register port; indices are word offsets.
 */
`ifndef PID_LOOP_MAP_VH
`define PID_LOOP_MAP_VH

// ****************************************
// register indices
// ****************************************
`define IDX_MODE_ONE      8'h00
`define IDX_SETPOINT      8'h02
`define IDX_CTRL_OUT      8'h05
`define IDX_MODE_STATUS   8'h06
`define IDX_MODE_REQ      8'h07
`define IDX_SP_UPPER      8'h08
`define IDX_SP_LOWER      8'h09
`define IDX_OUT_UPPER     8'h0a
`define IDX_OUT_LOWER     8'h0b
`define IDX_SAMPLE_PERIOD 8'h0c
`define IDX_BIAS          8'h0d

// ****************************************
// mode setting word one fields
// ****************************************
`define BIT_ALGO_VELOCITY 0
`define BIT_REVERSE       1
`define BIT_TRANSFER_TWO  3
`define BIT_WIDTH_LO      4
`define BIT_WIDTH_HI      5
`define BIT_BIPOLAR       6
`define BIT_SP_LIMIT_EN   7

// ****************************************
// data widths, modes, status bits
// ****************************************
`define WIDTH_12          2'h0
`define WIDTH_15          2'h1
`define WIDTH_16          2'h2
`define MAX_12            18'h00fff
`define MAX_15            18'h07fff
`define MAX_16            18'h0ffff
`define MODE_MANUAL       2'h0
`define MODE_AUTO         2'h1
`define MODE_CASCADE      2'h2
`define BIT_REQ_REFUSED   15

// ****************************************
// reset values and timing
// ****************************************
`define RST_WORD          16'h0000
`define RST_PERIOD        16'h0005
`define RST_OUT_UPPER     16'h0fff
`define PERIOD_MIN        16'h0005
`define PERIOD_MAX        16'h270f
`define PERIOD_UNIT_NS    10000000
`define CLK_PERIOD_NS     10

`endif

// ### pid_fmt_decode.v
/*
 * turns a loop data word into a signed working value.
 * assumes bipolar words are magnitude in bits 14:0 with sign in bit 15.
 */
`timescale 1ns/1ns
module pid_fmt_decode
(
   input  wire [15:0]        dataWord,
   input  wire               bipolar,
   output wire signed [17:0] value
);

   wire [17:0] magnitude;
   wire [17:0] unipolarVal;

   assign magnitude   = {3'h0, dataWord[14:0]};
   assign unipolarVal = {2'h0, dataWord};

   // sign-magnitude, never two's complement on the wire
   assign value = bipolar ? (dataWord[15] ? (18'h00000 - magnitude) : magnitude)
                          : unipolarVal;

endmodule

// ### pid_fmt_encode.v
/*
 * clamps a signed working value to the selected data range and
 * encodes it as a loop data word.
 * assumes the caller has already refused bipolar at 16-bit width.
 */
`timescale 1ns/1ns
`include "pid_loop_map.vh"
module pid_fmt_encode
(
   input  wire signed [17:0] value,
   input  wire [1:0]         widthSel,
   input  wire               bipolar,
   output reg  [15:0]        dataWord
);

   reg signed [17:0] rangeMax;
   reg signed [17:0] rangeMin;
   reg signed [17:0] clamped;
   reg        [17:0] magnitude;

   always @*
   begin
      rangeMax = (widthSel == `WIDTH_12) ? `MAX_12 :
                 (widthSel == `WIDTH_15) ? `MAX_15 : `MAX_16;
      rangeMin = bipolar ? (18'h00000 - rangeMax) : 18'h00000;
      clamped  = (value > rangeMax) ? rangeMax :
                 (value < rangeMin) ? rangeMin : value;
      magnitude = clamped[17] ? (18'h00000 - clamped) : clamped;
      if (bipolar)
         dataWord = {clamped[17], magnitude[14:0]};
      else
         dataWord = clamped[15:0];
   end

endmodule

// ### ladder_scan_model.sv
/*
 * scan model: the ladder task ending once every SCAN_CYCLES clocks.
 * assumes one clock shared with the loop controller.
 */
`timescale 1ns/1ns
module ladder_scan_model
#(
   parameter SCAN_CYCLES = 7
)
(
   input  wire clk_sys,
   input  wire rst_n,
   output reg  ladderDone
);
   reg [7:0] scanCnt;
   // ********
   // scan sequencer
   // ********
   // keeps pulsing in program mode so the loop alone must hold off
   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         scanCnt <= 8'h00;
         ladderDone <= 1'b0;
      end
      else
      begin
         ladderDone <= (scanCnt == SCAN_CYCLES - 1);
         scanCnt <= (scanCnt == SCAN_CYCLES - 1) ? 8'h00 : scanCnt + 8'h01;
      end
   end
endmodule

// ### pid_loop_mode_transfer_ctrl_asserts.sv
/*
 * port checks of the pid loop mode controller.
 * assumes one clock and an async active-low reset; bound to the top.
 */
`timescale 1ns/1ns
module pid_loop_mode_transfer_ctrl_asserts
#(
   parameter TICK_CYCLES = 10
)
(
   input wire        clk_sys,
   input wire        rst_n,
   input wire [7:0]  regAddr,
   input wire        regWr,
   input wire        regRd,
   input wire [15:0] regRdData,
   input wire        runMode,
   input wire        ladderDone,
   input wire [15:0] controlOut,
   input wire        calcDone
);
   reg [31:0] gap;
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   // ********
   // cycles since last calculation
   // ********
   // saturates so the first calculation after reset is not judged
   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         gap <= 32'hffffffff;
      else if (calcDone)
         gap <= 32'h00000000;
      else if (gap != 32'hffffffff)
         gap <= gap + 32'h00000001;
   end
   // ********
   // sequences and checks
   // ********
   sequence s_prog_held;
      !runMode [*4];
   endsequence
   sequence s_status_read;
      regRd && regAddr == 8'h06;
   endsequence
   chk_calc_after_ladder: assert property (calcDone |-> $past(ladderDone))
      else $error("calculation without ladder end");
   chk_calc_spacing: assert property (calcDone |-> gap >= 4 * TICK_CYCLES)
      else $error("calculations too close");
   chk_no_calc_prog: assert property (s_prog_held |=> !calcDone)
      else $error("calculation in program mode");
   chk_out_cause: assert property (!$stable(controlOut) |-> calcDone ||
      ($past(regWr) && ($past(regAddr) == 8'h05 || $past(regAddr) == 8'h07)))
      else $error("output changed without cause");
   chk_status_onehot: assert property (s_status_read |=> $onehot(regRdData[2:0]))
      else $error("status mode bits not one-hot");
   chk_req_code: assert property (regRd && regAddr == 8'h07 |=> regRdData[1:0] != 2'h3)
      else $error("illegal stored mode");
   chk_rd_idle: assert property (!regRd |=> regRdData == 16'h0000)
      else $error("read data outside answer cycle");
   chk_unmapped_zero: assert property (regRd && regAddr > 8'h0d |=> regRdData == 16'h0000)
      else $error("unmapped read nonzero");
endmodule

bind pid_loop_mode_transfer_ctrl pid_loop_mode_transfer_ctrl_asserts
   #(.TICK_CYCLES(TICK_CYCLES)) i_pid_loop_mode_transfer_ctrl_asserts
   (
      .clk_sys    (clk_sys),
      .rst_n      (rst_n),
      .regAddr    (regAddr),
      .regWr      (regWr),
      .regRd      (regRd),
      .regRdData  (regRdData),
      .runMode    (runMode),
      .ladderDone (ladderDone),
      .controlOut (controlOut),
      .calcDone   (calcDone)
   );

// ### tb_pid_loop_mode_transfer_ctrl.sv
/*
 * self-checking bench of the pid loop mode controller.
 * assumes the checker is bound in; 10 ms ticks shortened to 10 clocks.
 */
`timescale 1ns/1ns
module tb_pid_loop_mode_transfer_ctrl;
   reg         clk_sys;
   reg         rst_n;
   reg  [7:0]  regAddr;
   reg  [15:0] regWrData;
   reg         regWr;
   reg         regRd;
   wire [15:0] regRdData;
   reg         runMode;
   wire        ladderDone;
   reg  [15:0] measuredPv;
   reg  [15:0] cascadeSp;
   reg  [15:0] minorPv;
   wire [15:0] controlOut;
   wire        calcDone;
   integer     errors;
   integer     compares;
   integer     gap;

   pid_loop_mode_transfer_ctrl #(.TICK_CYCLES(10)) i_pid_loop_mode_transfer_ctrl
   (
      .clk_sys    (clk_sys),
      .rst_n      (rst_n),
      .regAddr    (regAddr),
      .regWrData  (regWrData),
      .regWr      (regWr),
      .regRd      (regRd),
      .regRdData  (regRdData),
      .runMode    (runMode),
      .ladderDone (ladderDone),
      .measuredPv (measuredPv),
      .cascadeSp  (cascadeSp),
      .minorPv    (minorPv),
      .controlOut (controlOut),
      .calcDone   (calcDone)
   );
   ladder_scan_model i_ladder_scan_model
   (
      .clk_sys    (clk_sys),
      .rst_n      (rst_n),
      .ladderDone (ladderDone)
   );
   // ********
   // bus and compare tasks
   // ********
   task ck(input [15:0] seen, input [15:0] exp);
   begin
      compares = compares + 1;
      if (seen !== exp)
      begin
         errors = errors + 1;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   end
   endtask
   task wr(input [7:0] a, input [15:0] d);
   begin
      @(posedge clk_sys);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge clk_sys);
      regWr <= 1'b0;
      #1;
   end
   endtask
   task rc(input [7:0] a, input [15:0] e);
   begin
      @(posedge clk_sys);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk_sys);
      regRd <= 1'b0;
      #1;
      ck(regRdData, e);
   end
   endtask
   // a missing calculation counts as a mismatch
   task wait_calc;
   begin
      gap = 0;
      do
      begin
         @(posedge clk_sys);
         #1;
         gap = gap + 1;
      end
      while (calcDone !== 1'b1 && gap < 400);
      ck({15'h0000, calcDone}, 16'h0001);
   end
   endtask
   task give_verdict;
   begin
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   end
   endtask
   // ********
   // clock, watchdog, sequence
   // ********
   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   initial
   begin
      repeat (20000) @(posedge clk_sys);
      errors = errors + 1;
      give_verdict;
   end
   initial
   begin
      errors = 0;
      compares = 0;
      regAddr = 8'h00;
      regWrData = 16'h0000;
      regWr = 1'b0;
      regRd = 1'b0;
      runMode = 1'b1;
      measuredPv = 16'h0300;
      cascadeSp = 16'h0000;
      minorPv = 16'h0000;
      rst_n = 1'b0;
      repeat (3) @(posedge clk_sys);
      rst_n <= 1'b1;
      rc(8'h00, 16'h0000);
      rc(8'h06, 16'h0001);
      rc(8'h0a, 16'h0fff);
      rc(8'h0c, 16'h0005);
      wr(8'h30, 16'h1234);
      rc(8'h30, 16'h0000);
      wr(8'h05, 16'h0123);
      repeat (120) @(posedge clk_sys);
      #1;
      ck(controlOut, 16'h0123);
      wr(8'h07, 16'h0002);
      rc(8'h07, 16'h8000);
      rc(8'h06, 16'h0001);
      rc(8'h02, 16'h0000);
      rc(8'h05, 16'h0123);
      wr(8'h02, 16'h0100);
      wr(8'h07, 16'h0001);
      rc(8'h02, 16'h0300);
      rc(8'h0d, 16'h0123);
      rc(8'h07, 16'h0001);
      rc(8'h06, 16'h0002);
      measuredPv <= 16'h0200;
      wait_calc;
      ck(controlOut, 16'h0223);
      wr(8'h00, 16'h0002);
      wait_calc;
      ck(controlOut, 16'h0023);
      wr(8'h00, 16'h0000);
      wr(8'h0a, 16'h0200);
      measuredPv <= 16'h0000;
      wait_calc;
      ck(controlOut, 16'h0200);
      wr(8'h0a, 16'h0000);
      wait_calc;
      ck(controlOut, 16'h0000);
      wr(8'h0a, 16'h0fff);
      wr(8'h0c, 16'h000a);
      wait_calc;
      wait_calc;
      ck({15'h0, gap >= 90 && gap <= 110}, 16'h0001);
      wr(8'h0c, 16'h0003);
      rc(8'h0c, 16'h0003);
      wait_calc;
      wait_calc;
      ck({15'h0, gap >= 41 && gap <= 60}, 16'h0001);
      measuredPv <= 16'h0100;
      minorPv <= 16'h0150;
      cascadeSp <= 16'h0180;
      wr(8'h07, 16'h0002);
      ck(controlOut, 16'h0150);
      rc(8'h06, 16'h0004);
      wait_calc;
      ck(controlOut, 16'h01a3);
      runMode <= 1'b0;
      measuredPv <= 16'h0000;
      repeat (6) @(posedge clk_sys);
      rc(8'h06, 16'h0001);
      wr(8'h07, 16'h0000);
      repeat (120) @(posedge clk_sys);
      #1;
      ck(controlOut, 16'h01a3);
      runMode <= 1'b1;
      repeat (4) @(posedge clk_sys);
      rc(8'h06, 16'h0004);
      wr(8'h07, 16'h0001);
      rc(8'h06, 16'h0002);
      wr(8'h07, 16'h0000);
      rc(8'h06, 16'h0001);
      wr(8'h00, 16'h0008);
      wr(8'h02, 16'h0100);
      wr(8'h05, 16'h0080);
      measuredPv <= 16'h0050;
      wr(8'h07, 16'h0001);
      rc(8'h02, 16'h0100);
      rc(8'h0d, 16'h0080);
      wait_calc;
      ck(controlOut, 16'h0130);
      minorPv <= 16'h0333;
      wr(8'h07, 16'h0002);
      ck(controlOut, 16'h0130);
      wr(8'h07, 16'h0000);
      wr(8'h00, 16'h0001);
      measuredPv <= 16'h0090;
      wr(8'h07, 16'h0001);
      rc(8'h02, 16'h0090);
      rc(8'h0d, 16'h0080);
      wr(8'h0d, 16'h5555);
      rc(8'h0d, 16'h0080);
      wr(8'h05, 16'h0200);
      wait_calc;
      ck(controlOut, 16'h0150);
      wr(8'h08, 16'h0060);
      wr(8'h00, 16'h0080);
      measuredPv <= 16'h0030;
      wait_calc;
      ck(controlOut, 16'h00b0);
      wr(8'h0b, 16'h8fff);
      wr(8'h00, 16'h0040);
      measuredPv <= 16'h0200;
      wait_calc;
      ck(controlOut, 16'h80f0);
      wr(8'h0b, 16'h0000);
      wr(8'h00, 16'h0060);
      wr(8'h02, 16'h8100);
      measuredPv <= 16'h8010;
      wait_calc;
      ck(controlOut, 16'h0170);
      wr(8'h00, 16'h0000);
      wr(8'h0a, 16'hffff);
      wr(8'h02, 16'h2000);
      measuredPv <= 16'h0000;
      wait_calc;
      ck(controlOut, 16'h0fff);
      give_verdict;
   end
endmodule
